// File: wmcg_pkg.sv
// Constants, register map and carrier types of the watch mode and module clock gating block.
package wmcg_pkg;
  localparam logic [15:0] ADDR_SYSCTL1 = 16'hFFF0;
  localparam logic [15:0] ADDR_SYSCTL2 = 16'hFFF1;
  localparam logic [15:0] ADDR_GATE1 = 16'hFFFA;
  localparam logic [15:0] ADDR_GATE2 = 16'hFFFB;
  localparam logic [15:0] ADDR_IRQ_STAT = 16'hFFE8;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'hFFE9;
  localparam int SOFTWARE_STANDBY_SELECT_BIT = 7;
  localparam int STS_MSB = 6;
  localparam int STS_LSB = 4;
  localparam int LOW_SPEED_WAKE_FLAG_BIT = 3;
  localparam int MEDIUM_SPEED_WAKE_FLAG_BIT = 2;
  localparam logic [7:0] SYSCTL1_RST = 8'h00;
  localparam logic [7:0] SYSCTL2_RST = 8'h00;
  localparam logic [7:0] GATE_RST = 8'hFF;
  localparam logic [7:0] GATE1_USED = 8'h7F;
  localparam logic [7:0] GATE2_USED = 8'h0F;
  localparam int G1_SCI1 = 6;
  localparam int G1_SCI2 = 5;
  localparam int G1_ADC = 4;
  localparam int G1_TMR_G = 3;
  localparam int G1_TMR_F = 2;
  localparam int G1_TMR_C = 1;
  localparam int G1_TMR_A = 0;
  localparam int G2_AEC = 3;
  localparam int G2_WDT = 2;
  localparam int G2_PWM = 1;
  localparam int G2_LCD = 0;
  localparam int IRQ_WATCH = 0;
  localparam int IRQ_INT_WAKE = 1;
  localparam int IRQ_RST_WAKE = 2;
  localparam int IRQ_WAIT_DONE = 3;
  localparam logic [3:0] IRQ_USED = 4'hF;
  localparam int CLK_PERIOD_NS = 5;
  localparam int STATE_PERIOD_NS = 5;
  localparam int STATE_CYCLES = (STATE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_STATES_0 = 8192;
  localparam int WAIT_STATES_1 = 16384;
  localparam int WAIT_STATES_2 = 32768;
  localparam int WAIT_STATES_3 = 65536;
  localparam int WAIT_STATES_4 = 131072;
  localparam int WAIT_STATES_5 = 2;
  localparam int WAIT_STATES_6 = 8;
  localparam int WAIT_STATES_7 = 16;
  localparam int WAIT_W = 18;
  typedef enum logic [2:0] {
    MODE_ACTIVE_HS = 3'b000,
    MODE_ACTIVE_MS = 3'b001,
    MODE_SUBACTIVE = 3'b010,
    MODE_WATCH = 3'b011,
    MODE_WAIT = 3'b100,
    MODE_RESET_OSC = 3'b101
  } wmcg_mode_t;
  typedef struct packed {
    logic irq0;
    logic [7:0] wakeup_pins;
    logic tmr_a;
    logic tmr_f;
    logic tmr_g;
  } wmcg_wake_t;
  typedef struct packed {
    logic sci1;
    logic sci2;
    logic adc;
    logic tmr_g;
    logic tmr_f;
    logic tmr_c;
    logic tmr_a;
    logic aec;
    logic wdt;
    logic pwm;
    logic lcd;
  } wmcg_pclk_t;
endpackage : wmcg_pkg

// File: wmcg_ctrl.sv
// Watch mode sequencer, standby wait timer and per-module clock gating.
`timescale 1ns/100ps
// What this block does
// RULE1 - Sleep with standby and timer bit enters watch
// RULE2 - Watch halts all but timers A, F, G, counter, LCD
// RULE3 - Watch keeps CPU state and holds ports
// RULE4 - Only listed interrupts or reset pin end watch
// RULE5 - Speed flags pick high, medium or subactive
// RULE6 - Active wake waits, then clock and exception
// RULE7 - Masked or disabled request keeps watch mode
// RULE8 - Reset pin runs oscillator, exception on release
// RULE9 - Reset pin held low until oscillator stable
// RULE10 - Clear gate bit stops that module clock
// RULE11 - Both gate registers reset to all ones
// RULE12 - First gate register maps seven modules
// RULE13 - Second gate register maps four modules
// RULE14 - Eight state code holds clocks eight states
// RULE15 - Wait field codes select eight wait lengths
// RULE16 - Unassigned gate bits read one, ignore writes
module wmcg_ctrl
  import wmcg_pkg::*;
#(
  parameter int P_WAIT_0 = WAIT_STATES_0,
  parameter int P_WAIT_1 = WAIT_STATES_1,
  parameter int P_WAIT_2 = WAIT_STATES_2,
  parameter int P_WAIT_3 = WAIT_STATES_3,
  parameter int P_WAIT_4 = WAIT_STATES_4
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_sleep,
  input wire logic i_timer_a_clock_select_msb,
  input wire logic i_cpu_int_mask,
  input wire wmcg_wake_t i_wake_req,
  input wire wmcg_wake_t i_wake_en,
  input wire logic i_external_reset_pin_n,
  input wire logic i_lcd_run_in_watch,
  output wmcg_mode_t o_mode,
  output logic o_cpu_clk_en,
  output wmcg_pclk_t o_pclk_en,
  output logic o_port_hold,
  output logic o_osc_run,
  output logic o_int_exc,
  output logic o_reset_exc,
  output logic o_irq
);

  wmcg_mode_t state_reg;
  wmcg_mode_t state_next;
  wmcg_mode_t tgt_reg;
  wmcg_mode_t tgt_next;
  logic [WAIT_W-1:0] cnt_reg;
  logic [WAIT_W-1:0] cnt_next;
  logic [7:0] sysctl1_reg;
  logic [7:0] sysctl2_reg;
  logic [7:0] gate1_reg;
  logic [7:0] gate2_reg;
  logic [3:0] stat_reg;
  logic [3:0] mask_reg;
  logic [3:0] ev;
  logic wake_hit;
  logic halted;
  logic in_watch;
  logic low_speed_wake_flag;
  logic medium_speed_wake_flag;
  logic [2:0] sts;

  // Each state is one bus clock here; the long codes are parameters so a test can shrink them.
  function automatic logic [WAIT_W-1:0] wait_cycles(input logic [2:0] code);
    int n;
    case (code) // RULE15
      3'b000: n = P_WAIT_0;
      3'b001: n = P_WAIT_1;
      3'b010: n = P_WAIT_2;
      3'b011: n = P_WAIT_3;
      3'b100: n = P_WAIT_4;
      3'b101: n = WAIT_STATES_5;
      3'b110: n = WAIT_STATES_6;
      default: n = WAIT_STATES_7;
    endcase
    n = n * STATE_CYCLES;
    return WAIT_W'(n - 1);
  endfunction : wait_cycles

  assign low_speed_wake_flag = sysctl1_reg[LOW_SPEED_WAKE_FLAG_BIT];
  assign medium_speed_wake_flag = sysctl2_reg[MEDIUM_SPEED_WAKE_FLAG_BIT];
  assign sts = sysctl1_reg[STS_MSB:STS_LSB];
  // Only enabled sources wake, and never while the CPU mask bit is set.
  assign wake_hit = (|(i_wake_req & i_wake_en)) & ~i_cpu_int_mask; // RULE4 RULE7

  always_comb begin
    state_next = state_reg;
    tgt_next = tgt_reg;
    cnt_next = cnt_reg;
    ev = 4'h0;
    case (state_reg)
      MODE_ACTIVE_HS, MODE_ACTIVE_MS, MODE_SUBACTIVE: begin
        if (i_sleep && sysctl1_reg[SOFTWARE_STANDBY_SELECT_BIT] && i_timer_a_clock_select_msb) begin
          state_next = MODE_WATCH; // RULE1
          ev[IRQ_WATCH] = 1'b1;
        end
      end
      MODE_WATCH: begin
        if (!i_external_reset_pin_n) begin
          state_next = MODE_RESET_OSC; // RULE8
        end else if (wake_hit) begin
          ev[IRQ_INT_WAKE] = 1'b1;
          if (low_speed_wake_flag) begin
            state_next = MODE_SUBACTIVE; // RULE5
          end else begin
            tgt_next = medium_speed_wake_flag ? MODE_ACTIVE_MS : MODE_ACTIVE_HS; // RULE5
            cnt_next = wait_cycles(sts); // RULE6 RULE14
            state_next = MODE_WAIT;
          end
        end
      end
      MODE_WAIT: begin
        if (cnt_reg == '0) begin
          state_next = tgt_reg; // RULE6
          ev[IRQ_WAIT_DONE] = 1'b1;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      MODE_RESET_OSC: begin
        // Stability is the pin driver's job: release is taken as oscillator settled.
        if (i_external_reset_pin_n) begin
          state_next = MODE_ACTIVE_HS; // RULE8 RULE9
          ev[IRQ_RST_WAKE] = 1'b1;
        end
      end
      default: state_next = MODE_ACTIVE_HS;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_reg <= MODE_ACTIVE_HS;
      tgt_reg <= MODE_ACTIVE_HS;
      cnt_reg <= '0;
    end else if (i_clk_en) begin
      state_reg <= state_next;
      tgt_reg <= tgt_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sysctl1_reg <= SYSCTL1_RST;
      sysctl2_reg <= SYSCTL2_RST;
      gate1_reg <= GATE_RST; // RULE11
      gate2_reg <= GATE_RST; // RULE11
    end else if (i_clk_en && i_wr) begin
      case (i_addr)
        ADDR_SYSCTL1: sysctl1_reg <= i_wdata;
        ADDR_SYSCTL2: sysctl2_reg <= i_wdata;
        ADDR_GATE1: gate1_reg <= i_wdata | ~GATE1_USED; // RULE16
        ADDR_GATE2: gate2_reg <= i_wdata | ~GATE2_USED; // RULE16
        default: ;
      endcase
    end
  end

  // A new event in the clearing cycle survives the write-one-to-clear.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      stat_reg <= 4'h0;
      mask_reg <= 4'h0;
    end else if (i_clk_en) begin
      if (i_wr && i_addr == ADDR_IRQ_STAT) begin
        stat_reg <= (stat_reg & ~i_wdata[3:0]) | ev;
      end else begin
        stat_reg <= stat_reg | ev;
      end
      if (i_wr && i_addr == ADDR_IRQ_MASK) begin
        mask_reg <= i_wdata[3:0] & IRQ_USED;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_clk_en) begin
      o_rdata <= 8'h00;
      if (i_rd) begin
        case (i_addr)
          ADDR_SYSCTL1: o_rdata <= sysctl1_reg;
          ADDR_SYSCTL2: o_rdata <= sysctl2_reg;
          ADDR_GATE1: o_rdata <= gate1_reg;
          ADDR_GATE2: o_rdata <= gate2_reg;
          ADDR_IRQ_STAT: o_rdata <= {4'h0, stat_reg};
          ADDR_IRQ_MASK: o_rdata <= {4'h0, mask_reg};
          default: o_rdata <= 8'h00;
        endcase
      end
    end
  end

  // The settling wait stops every clock, the watch-capable timers too.
  assign in_watch = (state_next == MODE_WATCH);
  assign halted = in_watch || (state_next == MODE_WAIT); // RULE14

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_mode <= MODE_ACTIVE_HS;
      o_cpu_clk_en <= 1'b1;
      o_port_hold <= 1'b0;
      o_osc_run <= 1'b1;
      o_int_exc <= 1'b0;
      o_reset_exc <= 1'b0;
      o_irq <= 1'b0;
    end else if (i_clk_en) begin
      o_mode <= state_next;
      o_cpu_clk_en <= !halted; // RULE3 RULE6
      o_port_hold <= in_watch; // RULE3
      o_osc_run <= !in_watch; // RULE8
      o_int_exc <= ev[IRQ_WAIT_DONE] || (ev[IRQ_INT_WAKE] && low_speed_wake_flag); // RULE6
      o_reset_exc <= ev[IRQ_RST_WAKE]; // RULE8
      o_irq <= |((stat_reg | ev) & mask_reg);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_pclk_en <= '1;
    end else if (i_clk_en) begin
      o_pclk_en.sci1 <= gate1_reg[G1_SCI1] && !halted; // RULE2 RULE10 RULE12
      o_pclk_en.sci2 <= gate1_reg[G1_SCI2] && !halted; // RULE12
      o_pclk_en.adc <= gate1_reg[G1_ADC] && !halted; // RULE12
      o_pclk_en.tmr_g <= gate1_reg[G1_TMR_G] && (!halted || in_watch); // RULE12
      o_pclk_en.tmr_f <= gate1_reg[G1_TMR_F] && (!halted || in_watch); // RULE12
      o_pclk_en.tmr_c <= gate1_reg[G1_TMR_C] && !halted; // RULE12
      o_pclk_en.tmr_a <= gate1_reg[G1_TMR_A] && (!halted || in_watch); // RULE12
      o_pclk_en.aec <= gate2_reg[G2_AEC] && (!halted || in_watch); // RULE13
      o_pclk_en.wdt <= gate2_reg[G2_WDT] && !halted; // RULE13
      o_pclk_en.pwm <= gate2_reg[G2_PWM] && !halted; // RULE13
      o_pclk_en.lcd <= gate2_reg[G2_LCD] && (!halted || (in_watch && i_lcd_run_in_watch)); // RULE2 RULE13
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_wake_active8;
    state_reg == MODE_WATCH && i_clk_en && i_external_reset_pin_n && wake_hit && !low_speed_wake_flag && sts == 3'b110;
  endsequence

  property p_watch_entry;
    (state_reg != MODE_WATCH) && (state_reg inside {MODE_ACTIVE_HS, MODE_ACTIVE_MS, MODE_SUBACTIVE})
      && i_clk_en && i_sleep && sysctl1_reg[SOFTWARE_STANDBY_SELECT_BIT] && i_timer_a_clock_select_msb |=> o_mode == MODE_WATCH;
  endproperty
  a_watch_entry: assert property (p_watch_entry) else $error("sleep did not enter watch"); // RULE1

  property p_watch_halt;
    o_mode == MODE_WATCH |-> !(o_pclk_en.sci1 || o_pclk_en.sci2 || o_pclk_en.adc || o_pclk_en.tmr_c
      || o_pclk_en.wdt || o_pclk_en.pwm);
  endproperty
  a_watch_halt: assert property (p_watch_halt) else $error("peripheral clocked in watch"); // RULE2

  property p_port_hold;
    o_mode == MODE_WATCH |-> o_port_hold && !o_cpu_clk_en && !o_osc_run;
  endproperty
  a_port_hold: assert property (p_port_hold) else $error("watch did not hold ports"); // RULE3

  property p_stay_watch;
    state_reg == MODE_WATCH && i_clk_en && i_external_reset_pin_n && (i_cpu_int_mask || !(|(i_wake_req & i_wake_en)))
      |=> o_mode == MODE_WATCH;
  endproperty
  a_stay_watch: assert property (p_stay_watch) else $error("watch left without wake"); // RULE4 RULE7

  property p_sub_wake;
    state_reg == MODE_WATCH && i_clk_en && i_external_reset_pin_n && wake_hit && low_speed_wake_flag
      |=> o_mode == MODE_SUBACTIVE && o_int_exc;
  endproperty
  a_sub_wake: assert property (p_sub_wake) else $error("subactive wake wrong"); // RULE5

  property p_eight_hold;
    s_wake_active8 |=> (!o_cpu_clk_en && !o_int_exc)[*8];
  endproperty
  a_eight_hold: assert property (p_eight_hold) else $error("clock released before eight states"); // RULE14

  property p_eight_release;
    s_wake_active8 ##1 i_clk_en[*8] |=> o_cpu_clk_en && o_int_exc && o_mode == (medium_speed_wake_flag ? MODE_ACTIVE_MS : MODE_ACTIVE_HS);
  endproperty
  a_eight_release: assert property (p_eight_release) else $error("wake not done after eight states"); // RULE6

  property p_reset_pin;
    state_reg == MODE_WATCH && i_clk_en && !i_external_reset_pin_n |=> o_mode == MODE_RESET_OSC && o_osc_run
      ##1 (!o_reset_exc || $past(i_external_reset_pin_n));
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin wake wrong"); // RULE8

  property p_gate_off;
    i_clk_en && !gate1_reg[G1_ADC] |=> !o_pclk_en.adc;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("gated module still clocked"); // RULE10

  property p_gate_reset;
    $fell(i_sys_rst) |-> gate1_reg == GATE_RST && gate2_reg == GATE_RST && o_pclk_en == '1;
  endproperty
  a_gate_reset: assert property (@(posedge i_mclk) p_gate_reset) else $error("gate reset value wrong"); // RULE11

  property p_unused_ones;
    i_clk_en && i_rd && i_addr == ADDR_GATE2 |=> o_rdata[7:4] == 4'hF;
  endproperty
  a_unused_ones: assert property (p_unused_ones) else $error("unused gate bits not one"); // RULE16

  // A refused sleep must leave the mode exactly where it was.
  property p_sleep_refused;
    state_reg inside {MODE_ACTIVE_HS, MODE_ACTIVE_MS, MODE_SUBACTIVE} && i_clk_en && i_sleep
      && !(sysctl1_reg[SOFTWARE_STANDBY_SELECT_BIT] && i_timer_a_clock_select_msb) |=> o_mode == $past(state_reg);
  endproperty
  a_sleep_refused: assert property (p_sleep_refused) else $error("refused sleep changed mode"); // RULE1

  sequence s_wake_wait;
    state_reg == MODE_WATCH && i_clk_en && i_external_reset_pin_n && wake_hit && !low_speed_wake_flag;
  endsequence

  property p_wake_wait;
    s_wake_wait |=> o_mode == MODE_WAIT && !o_cpu_clk_en && o_pclk_en == '0;
  endproperty
  a_wake_wait: assert property (p_wake_wait) else $error("active wake skipped the settling wait"); // RULE6

  property p_wait_dark;
    o_mode == MODE_WAIT |-> !o_cpu_clk_en && o_pclk_en == '0 && !o_int_exc;
  endproperty
  a_wait_dark: assert property (p_wait_dark) else $error("clock given during settling wait"); // RULE14

  property p_exc_pulse;
    o_int_exc && i_clk_en |=> !o_int_exc;
  endproperty
  a_exc_pulse: assert property (p_exc_pulse) else $error("interrupt exception not a pulse"); // RULE6

  property p_watch_quiet;
    o_mode == MODE_WATCH |-> !o_int_exc && !o_reset_exc;
  endproperty
  a_watch_quiet: assert property (p_watch_quiet) else $error("exception started inside watch"); // RULE4

  // The pin path never waits on the standby counter: the pin itself times the oscillator.
  property p_reset_clocks;
    o_mode == MODE_RESET_OSC |-> o_osc_run && o_cpu_clk_en && !o_port_hold;
  endproperty
  a_reset_clocks: assert property (p_reset_clocks) else $error("clocks off during pin reset"); // RULE8

  property p_reset_release;
    state_reg == MODE_RESET_OSC && i_clk_en && i_external_reset_pin_n
      |=> o_mode == MODE_ACTIVE_HS && o_reset_exc && o_cpu_clk_en;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("pin release did not start reset"); // RULE8

  property p_gate_follow;
    i_clk_en && !halted |=> o_pclk_en == $past({gate1_reg[G1_SCI1:G1_TMR_A], gate2_reg[G2_AEC:G2_LCD]});
  endproperty
  a_gate_follow: assert property (p_gate_follow) else $error("module clock differs from gate bit"); // RULE12

  property p_watch_keep;
    i_clk_en && state_next == MODE_WATCH
      |=> o_pclk_en.tmr_a == $past(gate1_reg[G1_TMR_A]) && o_pclk_en.aec == $past(gate2_reg[G2_AEC]);
  endproperty
  a_watch_keep: assert property (p_watch_keep) else $error("watch timer clock lost"); // RULE2

  property p_gate2_write;
    i_clk_en && i_wr && i_addr == ADDR_GATE2 |=> gate2_reg == ($past(i_wdata) | ~GATE2_USED);
  endproperty
  a_gate2_write: assert property (p_gate2_write) else $error("gate write not taken"); // RULE16

endmodule : wmcg_ctrl

// File: wmcg_cpu_model.sv
// CPU core and interrupt source model that faces the watch mode controller.
`timescale 1ns/100ps
module wmcg_cpu_model
  import wmcg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_osc_run,
  output logic o_sleep,
  output wmcg_wake_t o_wake_req,
  output logic o_reset_pin_n
);
  initial begin
    o_sleep = 1'b0;
    o_wake_req = '0;
    o_reset_pin_n = 1'b1;
  end
  task automatic sleep_op();
    @(posedge i_mclk) o_sleep <= 1'b1;
    @(posedge i_mclk) o_sleep <= 1'b0;
  endtask : sleep_op
  task automatic set_req(input wmcg_wake_t r);
    @(posedge i_mclk) o_wake_req <= r;
  endtask : set_req
  // The pin is released only after the oscillator has run for the settling count.
  task automatic pin_reset(input int settle);
    int k;
    k = 0;
    @(posedge i_mclk) o_reset_pin_n <= 1'b0;
    while (k < settle) begin
      @(posedge i_mclk);
      if (i_osc_run === 1'b1) k++;
    end
    o_reset_pin_n <= 1'b1;
  endtask : pin_reset
endmodule : wmcg_cpu_model

// File: tb_wmcg_ctrl.sv
// Self-checking bench for the watch mode and module clock gating block.
`timescale 1ns/100ps
module tb_wmcg_ctrl
  import wmcg_pkg::*;
;
  localparam int WTAB [8] = '{20, 24, 28, 32, 36, WAIT_STATES_5, WAIT_STATES_6, WAIT_STATES_7};
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_clk_en = 1'b1;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic tmsb = 1'b0;
  logic imask = 1'b0;
  logic lcd = 1'b0;
  wmcg_wake_t wen = '1;
  wmcg_wake_t req, src;
  logic sleep, pin_n, cpu_en, hold, osc, iexc, rexc, irq;
  logic [7:0] o_rdata;
  wmcg_mode_t o_mode;
  wmcg_pclk_t pclk;
  logic [7:0] g1 = 8'hFF;
  logic [7:0] g2 = 8'hFF;
  int failures = 0, tests_run = 0, seed = 87630, cyc = 0, n = 0;

  wmcg_ctrl #(.P_WAIT_0(WTAB[0]), .P_WAIT_1(WTAB[1]), .P_WAIT_2(WTAB[2]), .P_WAIT_3(WTAB[3]),
    .P_WAIT_4(WTAB[4])) uut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep(sleep),
    .i_timer_a_clock_select_msb(tmsb), .i_cpu_int_mask(imask), .i_wake_req(req), .i_wake_en(wen),
    .i_external_reset_pin_n(pin_n), .i_lcd_run_in_watch(lcd), .o_mode(o_mode), .o_cpu_clk_en(cpu_en),
    .o_pclk_en(pclk), .o_port_hold(hold), .o_osc_run(osc), .o_int_exc(iexc), .o_reset_exc(rexc),
    .o_irq(irq));
  wmcg_cpu_model cpu (.i_mclk(i_mclk), .i_osc_run(osc), .o_sleep(sleep), .o_wake_req(req),
    .o_reset_pin_n(pin_n));

  always #2.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_mclk) begin
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
    end
    @(posedge i_mclk) i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_mclk) begin
      i_rd <= 1'b1;
      i_addr <= a;
    end
    @(posedge i_mclk) i_rd <= 1'b0;
    @(negedge i_mclk) cmp({3'h0, o_rdata}, {3'h0, e});
  endtask : rd
  // Samples at the falling edge so registered outputs have settled.
  task automatic spin(input wmcg_mode_t m, input bit stay);
    n = 0;
    @(negedge i_mclk);
    while (((o_mode === m) == stay) && n < 300) begin
      @(negedge i_mclk);
      n++;
    end
  endtask : spin
  function automatic logic [10:0] pexp(input bit w);
    logic [10:0] v;
    v = {g1[6:0], g2[3:0]};
    if (w) v = v & (11'h0D8 | {10'h000, lcd});
    return v;
  endfunction : pexp
  task automatic enter_watch();
    cpu.sleep_op();
    spin(MODE_WATCH, 1'b0);
    cmp({o_mode, hold, osc, irq}, {MODE_WATCH, 3'b100});
    cmp(pclk, pexp(1'b1));
  endtask : enter_watch

  initial begin
    repeat (16) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    rd(ADDR_GATE1, 8'hFF);
    rd(ADDR_GATE2, 8'hFF);
    rd(16'h1234, 8'h00);
    cmp(pclk, 11'h7FF);
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      g1 = 8'($random(seed));
      g2 = 8'($random(seed));
      wr(ADDR_GATE1, g1);
      wr(ADDR_GATE2, g2);
      g1 = g1 | ~GATE1_USED;
      g2 = g2 | ~GATE2_USED;
      rd(ADDR_GATE1, g1);
      rd(ADDR_GATE2, g2);
      cmp(pclk, pexp(1'b0));
    end
    @(posedge i_mclk) i_clk_en <= 1'b0;
    wr(ADDR_GATE1, ~g1);
    @(posedge i_mclk) i_clk_en <= 1'b1;
    rd(ADDR_GATE1, g1);
    cmp(pclk, pexp(1'b0));
    $display("gate test done");
    wr(ADDR_SYSCTL1, 8'h80);
    cpu.sleep_op();
    repeat (4) @(negedge i_mclk);
    cmp(o_mode, MODE_ACTIVE_HS);
    @(posedge i_mclk) tmsb <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      lcd <= c[1];
      src = wmcg_wake_t'(11'h001 << ($unsigned($random(seed)) % 11));
      wr(ADDR_SYSCTL1, {1'b1, 3'(c), 4'h0});
      wr(ADDR_SYSCTL2, {5'h00, c[0], 2'h0});
      enter_watch();
      if (c == 0) begin
        @(posedge i_mclk) imask <= 1'b1;
        cpu.set_req(src);
        repeat (8) @(negedge i_mclk);
        cmp(o_mode, MODE_WATCH);
        @(posedge i_mclk) begin
          imask <= 1'b0;
          wen <= '0;
        end
        repeat (8) @(negedge i_mclk);
        cmp(o_mode, MODE_WATCH);
        @(posedge i_mclk) wen <= '1;
      end
      cpu.set_req(src);
      spin(MODE_WAIT, 1'b0);
      cmp(pclk | 11'(cpu_en), 11'h000);
      spin(MODE_WAIT, 1'b1);
      // The first wait cycle was already seen by the spin that found the wait mode.
      cmp(11'(n + 1), 11'(WTAB[c]));
      cmp({o_mode, iexc, cpu_en}, {c[0] ? MODE_ACTIVE_MS : MODE_ACTIVE_HS, 2'b11});
      cmp(pclk, pexp(1'b0));
      cpu.set_req('0);
      $display("wake test code %0d done", c);
    end
    wr(ADDR_SYSCTL1, 8'h88);
    enter_watch();
    cpu.set_req(src);
    spin(MODE_SUBACTIVE, 1'b0);
    cmp({o_mode, iexc}, {MODE_SUBACTIVE, 1'b1});
    cpu.set_req('0);
    enter_watch();
    fork
      cpu.pin_reset(12);
      begin
        spin(MODE_RESET_OSC, 1'b0);
        cmp({o_mode, osc, cpu_en}, {MODE_RESET_OSC, 2'b11});
      end
    join
    spin(MODE_RESET_OSC, 1'b1);
    cmp({o_mode, rexc}, {MODE_ACTIVE_HS, 1'b1});
    $display("subactive and reset pin test done");
    rd(ADDR_IRQ_STAT, 8'h0F);
    wr(ADDR_IRQ_MASK, 8'h02);
    repeat (2) @(negedge i_mclk);
    cmp(irq, 1'b1);
    wr(ADDR_IRQ_STAT, 8'h0F);
    rd(ADDR_IRQ_STAT, 8'h00);
    cmp(irq, 1'b0);
    $display("interrupt test done");
    tally_and_finish();
  end
endmodule : tb_wmcg_ctrl
